/* logic/hss_pkg.sv */
// Package of constants and types for the high-side switch control block
//
// Contract
// - Each output is driven by its own setting, a timer, or a PWM generator.
// - Configuration writes are taken only in normal mode; held in stop and sleep.
// - Every output is disabled in restart and fail-safe modes.
// - After restart or fail-safe, software may re-enable outputs once the fault clears.
// - Supply over-voltage switches on outputs off; they return per recovery setting.
// - Supply under-voltage switches outputs off; they return per recovery setting.
// - Two control bits disable over-voltage and under-voltage shutdown independently.
// - Recovery set restores programmed state; otherwise outputs stay off, codes cleared.
// - Supply faults show only in the two supply flags, no other error flag.
// - Output switches off when over-current lasts longer than the filter time.
// - Over-current shutdown sets the output's flag and forces its code to 000.
// - Over-current flags stay set until software clears them.
// - Open load on an on output sets its flag and keeps the output on.
// - Open-load flags stay set until software clears them.
// - In stop and sleep, outputs run and all protections stay active.
// - Over-current filter time is 16 microseconds.
// - Open-load filter time is 64 microseconds.
// - Two 8-bit PWM generators at 200 Hz or 400 Hz, assignable to any output.
package hss_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ       = 200;
   localparam int OC_FILT_US    = 16;
   localparam int OL_FILT_US    = 64;
   localparam int OC_FILT_CYC   = OC_FILT_US * CLK_MHZ;
   localparam int OL_FILT_CYC   = OL_FILT_US * CLK_MHZ;
   localparam int PWM_HZ_LO     = 200;
   localparam int PWM_HZ_HI     = 400;
   localparam int PWM_STEP_LO   = (CLK_MHZ * 1000000) / (PWM_HZ_LO * 256);
   localparam int PWM_STEP_HI   = (CLK_MHZ * 1000000) / (PWM_HZ_HI * 256);
   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL_LOW   = 8'h00;
   localparam logic [7:0] ADDR_CTRL_HIGH  = 8'h04;
   localparam logic [7:0] ADDR_SUPPLY_CFG = 8'h08;
   localparam logic [7:0] ADDR_OC_STATUS  = 8'h0C;
   localparam logic [7:0] ADDR_OL_STATUS  = 8'h10;
   localparam logic [7:0] ADDR_PWM1       = 8'h14;
   localparam logic [7:0] ADDR_PWM2       = 8'h18;
   localparam logic [7:0] ADDR_PWM_FREQ   = 8'h1C;
   localparam logic [7:0] ADDR_SUPPLY_ST  = 8'h20;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int          CFG_W        = 3;
   localparam int          BIT_OV_DIS   = 0;
   localparam int          BIT_UV_DIS   = 1;
   localparam int          BIT_RECOVER  = 2;
   localparam int          BIT_OV_FLAG  = 0;
   localparam int          BIT_UV_FLAG  = 1;
   localparam logic [2:0]  CFG_RST      = 3'h0;
   localparam logic [2:0]  SUPPLY_RST   = 3'h0;
   localparam logic [7:0]  DUTY_RST     = 8'h00;
   // Source codes
   localparam logic [2:0]  SRC_OFF      = 3'h0;
   localparam logic [2:0]  SRC_ON       = 3'h1;
   localparam logic [2:0]  SRC_TIMER1   = 3'h2;
   localparam logic [2:0]  SRC_TIMER2   = 3'h3;
   localparam logic [2:0]  SRC_PWM1     = 3'h4;
   localparam logic [2:0]  SRC_PWM2     = 3'h5;
   // Chip modes
   typedef enum logic [2:0] {
      MODE_NORMAL, MODE_STOP, MODE_SLEEP, MODE_RESTART, MODE_FAILSAFE
   } hss_mode_e;
endpackage

/* logic/hss_chan_if.sv */
// Interface carrying one output channel's filter signals
`timescale 1ns/1ps
`default_nettype none
interface hss_chan_if;
   logic on;    // Output is driven on
   logic cond;  // Raw synchronised condition
   logic hit;   // Filtered condition, high while it persists past the count
   modport filt (input on, input cond, output hit);
   modport ctrl (output on, output cond, input hit);
endinterface
`default_nettype wire

/* logic/hss_filter.sv */
// Persistence filter: stays high while a condition holds while on, once held for a count
`timescale 1ns/1ps
`default_nettype none
module hss_filter #(
   parameter int COUNT = 16
) (
   input  wire logic   i_mclk,   // Clock
   input  wire logic   i_rst_n,  // Sync reset, active low
   input  wire logic   i_ce,     // Clock enable
   hss_chan_if.filt    ch        // Channel signals
);
   localparam int CW = $clog2(COUNT + 1);
   logic [CW-1:0] cnt_q;
   // Count while the condition persists; restart when it drops
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
      end else if (i_ce) begin
         if (!(ch.on && ch.cond)) begin
            cnt_q <= '0;
         end else if (cnt_q != CW'(COUNT)) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
   assign ch.hit = ch.on && ch.cond && (cnt_q == CW'(COUNT));
endmodule
`default_nettype wire

/* logic/hss_top.sv */
// High-side switch control: sources, supply and load protection, APB registers
`timescale 1ns/1ps
`default_nettype none
module hss_top #(
   parameter int NUM_OUT   = 4,
   parameter int OC_CYCLES = hss_pkg::OC_FILT_CYC,
   parameter int OL_CYCLES = hss_pkg::OL_FILT_CYC,
   parameter int PWM_LO    = hss_pkg::PWM_STEP_LO,
   parameter int PWM_HI    = hss_pkg::PWM_STEP_HI
) (
   input  wire logic               i_mclk,     // 200 MHz clock
   input  wire logic               i_rst_n,    // Sync reset, active low
   input  wire logic               i_ce,       // Clock enable
   input  wire logic               i_psel,     // APB select
   input  wire logic               i_penable,  // APB enable
   input  wire logic               i_pwrite,   // APB write
   input  wire logic [7:0]         i_paddr,    // APB byte address
   input  wire logic [31:0]        i_pwdata,   // APB write data
   output logic      [31:0]        o_prdata,   // APB read data
   output logic                    o_pready,   // APB ready
   output logic                    o_pslverr,  // APB error
   input  wire logic [2:0]         i_mode,     // Chip mode code
   input  wire logic [1:0]         i_timer,    // Timer 1/2 outputs
   input  wire logic               i_supply_ov,// Switch supply over-voltage
   input  wire logic               i_supply_uv,// Switch supply under-voltage
   input  wire logic [NUM_OUT-1:0] i_oc,       // Load over-current comparators
   input  wire logic [NUM_OUT-1:0] i_ol,       // Load open-load comparators
   output logic      [NUM_OUT-1:0] o_switch_on // Load switch drive
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int SW = 2 * NUM_OUT + 4;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   // Two stages for all analog comparator inputs
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (i_ce) begin
         sync1_q <= {i_oc, i_ol, i_timer, i_supply_ov, i_supply_uv};
         sync2_q <= sync1_q;
      end
   end
   logic [NUM_OUT-1:0] oc_s;
   logic [NUM_OUT-1:0] ol_s;
   logic [1:0]         timer_s;
   logic               ov_s;
   logic               uv_s;
   assign {oc_s, ol_s, timer_s, ov_s, uv_s} = sync2_q;

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   hss_pkg::hss_mode_e mode;
   logic               normal;
   logic               shut_mode;
   assign mode      = hss_pkg::hss_mode_e'(i_mode);
   assign normal    = (mode == hss_pkg::MODE_NORMAL);
   assign shut_mode = (mode == hss_pkg::MODE_RESTART) || (mode == hss_pkg::MODE_FAILSAFE);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic wr;
   logic rd;
   logic mapped;
   assign wr       = i_psel && i_penable && i_pwrite && i_ce;
   assign rd       = i_psel && i_penable && !i_pwrite && i_ce;
   assign o_pready = 1'b1;
   always_comb begin
      case (i_paddr)
         hss_pkg::ADDR_CTRL_LOW, hss_pkg::ADDR_CTRL_HIGH, hss_pkg::ADDR_SUPPLY_CFG,
         hss_pkg::ADDR_OC_STATUS, hss_pkg::ADDR_OL_STATUS, hss_pkg::ADDR_PWM1,
         hss_pkg::ADDR_PWM2, hss_pkg::ADDR_PWM_FREQ, hss_pkg::ADDR_SUPPLY_ST: begin
            mapped = 1'b1;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end
   assign o_pslverr = i_psel && i_penable && !mapped;
   // Configuration writes are accepted only in normal mode
   logic cfg_wr;
   assign cfg_wr = wr && normal;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic [2:0] cfg_q [NUM_OUT];
   logic [2:0] supply_cfg_q;
   logic [7:0] duty_q [2];
   logic [1:0] freq_q;
   logic       supply_fault;
   logic       supply_fault_q;
   logic [NUM_OUT-1:0] oc_hit;
   logic [NUM_OUT-1:0] ol_hit;
   // Supply fault tracking: OV and UV gated by their disable bits
   assign supply_fault = (ov_s && !supply_cfg_q[hss_pkg::BIT_OV_DIS])
                      || (uv_s && !supply_cfg_q[hss_pkg::BIT_UV_DIS]);
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         supply_fault_q <= 1'b0;
      end else if (i_ce) begin
         supply_fault_q <= supply_fault;
      end
   end
   // Per-output source codes; hardware clears win over software writes
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         for (int k = 0; k < NUM_OUT; k++) begin
            cfg_q[k] <= hss_pkg::CFG_RST;
         end
      end else if (i_ce) begin
         for (int k = 0; k < NUM_OUT; k++) begin
            if (cfg_wr && i_paddr == hss_pkg::ADDR_CTRL_LOW && k < 2) begin
               cfg_q[k] <= i_pwdata[k*4 +: 3];
            end
            if (cfg_wr && i_paddr == hss_pkg::ADDR_CTRL_HIGH && k >= 2) begin
               cfg_q[k] <= i_pwdata[(k-2)*4 +: 3];
            end
            if (oc_hit[k]) begin
               cfg_q[k] <= hss_pkg::SRC_OFF;
            end
            if (supply_fault && !supply_fault_q
                && !supply_cfg_q[hss_pkg::BIT_RECOVER]) begin
               cfg_q[k] <= hss_pkg::SRC_OFF;
            end
         end
      end
   end
   // Supply control bits, PWM duty and frequency
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         supply_cfg_q <= hss_pkg::SUPPLY_RST;
         duty_q[0]    <= hss_pkg::DUTY_RST;
         duty_q[1]    <= hss_pkg::DUTY_RST;
         freq_q       <= 2'h0;
      end else if (cfg_wr) begin
         case (i_paddr)
            hss_pkg::ADDR_SUPPLY_CFG: begin
               supply_cfg_q <= i_pwdata[2:0];
            end
            hss_pkg::ADDR_PWM1: begin
               duty_q[0] <= i_pwdata[7:0];
            end
            hss_pkg::ADDR_PWM2: begin
               duty_q[1] <= i_pwdata[7:0];
            end
            hss_pkg::ADDR_PWM_FREQ: begin
               freq_q <= i_pwdata[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // PWM generators
   // ----------------------------------------------------------------
   localparam int PCW = $clog2(PWM_LO + 1);
   logic [PCW-1:0] pre_q [2];
   logic [7:0]     phase_q [2];
   logic [1:0]     pwm;
   // Prescaler per generator, 256 phase steps per period
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         for (int g = 0; g < 2; g++) begin
            pre_q[g]   <= '0;
            phase_q[g] <= 8'h00;
         end
      end else if (i_ce) begin
         for (int g = 0; g < 2; g++) begin
            if (pre_q[g] >= PCW'((freq_q[g] ? PWM_HI : PWM_LO) - 1)) begin
               pre_q[g]   <= '0;
               phase_q[g] <= phase_q[g] + 8'h01;
            end else begin
               pre_q[g] <= pre_q[g] + 1'b1;
            end
         end
      end
   end
   assign pwm[0] = phase_q[0] < duty_q[0];
   assign pwm[1] = phase_q[1] < duty_q[1];

   // ----------------------------------------------------------------
   // Output drive and load protection
   // ----------------------------------------------------------------
   logic [NUM_OUT-1:0] drive;
   logic [NUM_OUT-1:0] on_q;
   // Source select, then gate with mode and supply shutdown
   always_comb begin
      for (int k = 0; k < NUM_OUT; k++) begin
         case (cfg_q[k])
            hss_pkg::SRC_ON:     drive[k] = 1'b1;
            hss_pkg::SRC_TIMER1: drive[k] = timer_s[0];
            hss_pkg::SRC_TIMER2: drive[k] = timer_s[1];
            hss_pkg::SRC_PWM1:   drive[k] = pwm[0];
            hss_pkg::SRC_PWM2:   drive[k] = pwm[1];
            default:             drive[k] = 1'b0;
         endcase
      end
   end
   // Registered drive; protections apply in every running mode
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         on_q <= '0;
      end else if (i_ce) begin
         on_q <= drive & ~oc_hit & {NUM_OUT{!shut_mode && !supply_fault}};
      end
   end
   assign o_switch_on = on_q;

   // Filters per output, over-current and open-load
   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUT; gi++) begin : g_ch
         hss_chan_if oc_if ();
         hss_chan_if ol_if ();
         assign oc_if.on   = on_q[gi];
         assign oc_if.cond = oc_s[gi];
         assign ol_if.on   = on_q[gi];
         assign ol_if.cond = ol_s[gi];
         assign oc_hit[gi] = oc_if.hit;
         assign ol_hit[gi] = ol_if.hit;
         hss_filter #(.COUNT(OC_CYCLES)) u_oc (
            .i_mclk  (i_mclk),
            .i_rst_n (i_rst_n),
            .i_ce    (i_ce),
            .ch      (oc_if)
         );
         hss_filter #(.COUNT(OL_CYCLES)) u_ol (
            .i_mclk  (i_mclk),
            .i_rst_n (i_rst_n),
            .i_ce    (i_ce),
            .ch      (ol_if)
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   logic [NUM_OUT-1:0] oc_flag_q;
   logic [NUM_OUT-1:0] ol_flag_q;
   logic [1:0]         sup_flag_q;
   // Sticky load flags: write one to clear, set wins over clear
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         oc_flag_q <= '0;
         ol_flag_q <= '0;
      end else if (i_ce) begin
         oc_flag_q <= (oc_flag_q & ~((wr && i_paddr == hss_pkg::ADDR_OC_STATUS)
                      ? i_pwdata[NUM_OUT-1:0] : '0)) | oc_hit;
         ol_flag_q <= (ol_flag_q & ~((wr && i_paddr == hss_pkg::ADDR_OL_STATUS)
                      ? i_pwdata[NUM_OUT-1:0] : '0)) | ol_hit;
      end
   end
   // Supply flags follow the synchronised comparators
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         sup_flag_q <= 2'h0;
      end else if (i_ce) begin
         sup_flag_q[hss_pkg::BIT_OV_FLAG] <= ov_s;
         sup_flag_q[hss_pkg::BIT_UV_FLAG] <= uv_s;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_ce && i_psel && !i_penable && !i_pwrite) begin
         case (i_paddr)
            hss_pkg::ADDR_CTRL_LOW:   o_prdata <= {25'h0, cfg_q[1], 1'b0, cfg_q[0]};
            hss_pkg::ADDR_CTRL_HIGH:  o_prdata <= {25'h0, cfg_q[3], 1'b0, cfg_q[2]};
            hss_pkg::ADDR_SUPPLY_CFG: o_prdata <= {29'h0, supply_cfg_q};
            hss_pkg::ADDR_OC_STATUS:  o_prdata <= {{(32-NUM_OUT){1'b0}}, oc_flag_q};
            hss_pkg::ADDR_OL_STATUS:  o_prdata <= {{(32-NUM_OUT){1'b0}}, ol_flag_q};
            hss_pkg::ADDR_PWM1:       o_prdata <= {24'h0, duty_q[0]};
            hss_pkg::ADDR_PWM2:       o_prdata <= {24'h0, duty_q[1]};
            hss_pkg::ADDR_PWM_FREQ:   o_prdata <= {30'h0, freq_q};
            hss_pkg::ADDR_SUPPLY_ST:  o_prdata <= {30'h0, sup_flag_q};
            default:                  o_prdata <= 32'h0000_0000;
         endcase
      end
   end
   logic unused;
   assign unused = rd;
endmodule
`default_nettype wire

/* dv/hss_asserts.sv */
// Concurrent checks on the ports of the high-side switch control block
`timescale 1ns/1ps
`default_nettype none
module hss_asserts #(
   parameter int NUM_OUT   = 4,
   parameter int OC_CYCLES = 8
) (
   input wire logic               i_mclk,      // Clock
   input wire logic               i_rst_n,     // Sync reset, active low
   input wire logic               i_ce,        // Clock enable
   input wire logic               i_psel,      // APB select
   input wire logic               i_penable,   // APB enable
   input wire logic               i_pwrite,    // APB write
   input wire logic [7:0]         i_paddr,     // APB address
   input wire logic [31:0]        i_pwdata,    // APB write data
   input wire logic [31:0]        o_prdata,    // APB read data
   input wire logic               o_pready,    // APB ready
   input wire logic               o_pslverr,   // APB error
   input wire logic [2:0]         i_mode,      // Chip mode
   input wire logic [1:0]         i_timer,     // Timer levels
   input wire logic               i_supply_ov, // Supply over-voltage
   input wire logic               i_supply_uv, // Supply under-voltage
   input wire logic [NUM_OUT-1:0] i_oc,        // Over-current comparators
   input wire logic [NUM_OUT-1:0] i_ol,        // Open-load comparators
   input wire logic [NUM_OUT-1:0] o_switch_on  // Switch drive
);
   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   logic [NUM_OUT-1:0][15:0] oc_run_q;  // Cycles on with over-current present
   logic                     oc_long;   // An output outlived the filter
   logic                     mapped;    // Address hits a register
   logic                     access;    // APB access phase
   assign mapped = (i_paddr[1:0] == 2'b00) && (i_paddr <= hss_pkg::ADDR_SUPPLY_ST);
   assign access = i_psel && i_penable;
   // Count how long each output stays on into an over-current
   always_ff @(posedge i_mclk) begin
      for (int k = 0; k < NUM_OUT; k++) begin
         if (!i_rst_n || !(o_switch_on[k] && i_oc[k])) begin
            oc_run_q[k] <= 16'h0000;
         end else if (i_ce) begin
            oc_run_q[k] <= oc_run_q[k] + 16'h0001;
         end
      end
   end
   // Sync stages plus filter plus one edge bound the on time
   always_comb begin
      oc_long = 1'b0;
      for (int k = 0; k < NUM_OUT; k++) oc_long |= (oc_run_q[k] > 16'(OC_CYCLES + 8));
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   ready_const_a: assert property (o_pready) else $error("pready dropped");
   unmapped_err_a: assert property (access && !mapped |-> o_pslverr && (i_pwrite || o_prdata == '0))
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (!access || mapped |-> !o_pslverr) else $error("spurious pslverr");
   read_hold_a: assert property (access && !i_pwrite |=> o_prdata == $past(o_prdata))
      else $error("read data moved after access");
   reset_clear_a: assert property ($rose(i_rst_n) |-> o_switch_on == '0 && o_prdata == '0)
      else $error("outputs not cleared by reset");
   ce_freeze_a: assert property (!i_ce |=> $stable(o_switch_on)) else $error("drive moved with ce low");
   restart_off_a: assert property ((i_ce && (i_mode == hss_pkg::MODE_RESTART ||
      i_mode == hss_pkg::MODE_FAILSAFE))[*4] |-> o_switch_on == '0) else $error("output on in restart");
   oc_cut_a: assert property (!oc_long) else $error("over-current output left on");
   // Main scenarios reached
   cover property (access && o_pslverr);
   cover property ($fell(o_switch_on[0]) && i_oc[0]);
   cover property (i_mode == hss_pkg::MODE_STOP && o_switch_on[0]);
endmodule
`default_nettype wire

/* dv/hss_load_model.sv */
// Behavioural loads on the four switch outputs with their current comparators
`timescale 1ns/1ps
`default_nettype none
module hss_load_model (
   input  wire logic [3:0] i_switch_on, // Drive from the block
   input  wire logic       i_mclk,      // Clock
   input  wire logic [3:0] i_short,     // Loads shorted
   input  wire logic [3:0] i_open,      // Loads disconnected
   output logic      [3:0] o_oc = 4'h0, // Over-current comparators
   output logic      [3:0] o_ol = 4'h0  // Open-load comparators
);
   // Comparators see current only while driven
   always @(posedge i_mclk) begin
      o_oc <= i_switch_on & i_short;
      o_ol <= i_switch_on & i_open;
   end
endmodule
`default_nettype wire

/* dv/test_high_side_switch_control.sv */
// Self-checking bench for the high-side switch control block
`timescale 1ns/1ps
`default_nettype none
module test_high_side_switch_control;
   localparam int OCC = 8;
   localparam int OLC = 16;
   localparam int PLO = 4;
   localparam int PHI = 2;
   localparam logic [7:0] CL = hss_pkg::ADDR_CTRL_LOW, CH = hss_pkg::ADDR_CTRL_HIGH;
   localparam logic [7:0] SC = hss_pkg::ADDR_SUPPLY_CFG, SS = hss_pkg::ADDR_SUPPLY_ST;
   localparam logic [7:0] OCS = hss_pkg::ADDR_OC_STATUS, OLS = hss_pkg::ADDR_OL_STATUS;
   logic        mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, sup_ov = 1'b0, sup_uv = 1'b0;
   logic [2:0]  mode = 3'h0;
   logic [1:0]  timer = 2'h0;
   logic [3:0]  oc, ol, sw_on, short = 4'h0, open = 4'h0;
   int          n_fail = 0, n_checks = 0, tmo = 0;
   hss_top #(.OC_CYCLES(OCC), .OL_CYCLES(OLC), .PWM_LO(PLO), .PWM_HI(PHI)) u_dut (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_mode(mode), .i_timer(timer),
      .i_supply_ov(sup_ov), .i_supply_uv(sup_uv), .i_oc(oc), .i_ol(ol), .o_switch_on(sw_on));
   hss_load_model u_load (.i_switch_on(sw_on), .i_mclk(mclk), .i_short(short), .i_open(open),
      .o_oc(oc), .o_ol(ol));
   // ----------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------------------------------
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      tmo++;
      if (tmo == 30000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // One APB transfer, then one idle edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk($sformatf("register %h", a), exp, q);
   endtask
   // Wait n edges, then compare the switch drive
   task automatic sw(input int n, input logic [3:0] exp);
      cyc(n);
      chk("switch drive", 32'(exp), 32'(sw_on));
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic s_regs();
      logic [31:0] q;
      logic        e;
      for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0000_0000);
      apb(1'b0, 8'h24, 32'h0000_0000, q, e);
      chk("unmapped error", 32'h0000_0001, 32'(e));
      chk("unmapped data", 32'h0000_0000, q);
   endtask
   task automatic s_sources();
      int c2 = 0, c3 = 0;
      wr(CL, 32'h0000_0021);
      wr(CH, 32'h0000_0073);
      sw(5, 4'b0001);
      timer <= 2'b01;
      sw(5, 4'b0011);
      timer <= 2'b10;
      sw(5, 4'b0101);
      ce <= 1'b0;
      timer <= 2'b01;
      sw(5, 4'b0101);
      ce <= 1'b1;
      sw(5, 4'b0011);
      wr(hss_pkg::ADDR_PWM1, 32'h0000_0080);
      wr(hss_pkg::ADDR_PWM2, 32'h0000_0040);
      wr(hss_pkg::ADDR_PWM_FREQ, 32'h0000_0002);
      wr(CH, 32'h0000_0054);
      cyc(8);
      for (int i = 0; i < 256 * PLO; i++) begin
         @(posedge mclk);
         c2 += int'(sw_on[2]);
         c3 += int'(sw_on[3]);
      end
      chk("pwm1 on time", 32'(128 * PLO), 32'(c2));
      chk("pwm2 on time", 32'(2 * 64 * PHI), 32'(c3));
      wr(CL, 32'h0000_0001);
      wr(CH, 32'h0000_0000);
      cyc(5);
   endtask
   task automatic s_modes();
      mode <= hss_pkg::MODE_STOP;
      cyc(2);
      wr(CL, 32'h0000_0000);
      rd(CL, 32'h0000_0001);
      sw(0, 4'b0001);
      mode <= hss_pkg::MODE_SLEEP;
      cyc(2);
      wr(CH, 32'h0000_0001);
      rd(CH, 32'h0000_0000);
      mode <= hss_pkg::MODE_RESTART;
      sw(6, 4'b0000);
      mode <= hss_pkg::MODE_FAILSAFE;
      sw(6, 4'b0000);
      mode <= hss_pkg::MODE_NORMAL;
      cyc(2);
      wr(CL, 32'h0000_0001);
      sw(5, 4'b0001);
   endtask
   task automatic s_supply();
      wr(SC, 32'h0000_0004);
      sup_ov <= 1'b1;
      sw(6, 4'b0000);
      rd(SS, 32'h0000_0001);
      rd(OCS, 32'h0000_0000);
      rd(OLS, 32'h0000_0000);
      sup_ov <= 1'b0;
      sw(6, 4'b0001);
      sup_uv <= 1'b1;
      sw(6, 4'b0000);
      rd(SS, 32'h0000_0002);
      sup_uv <= 1'b0;
      sw(6, 4'b0001);
      wr(SC, 32'h0000_0007);
      sup_ov <= 1'b1;
      sup_uv <= 1'b1;
      sw(6, 4'b0001);
      wr(SC, 32'h0000_0005);
      sw(5, 4'b0000);
      sup_ov <= 1'b0;
      sup_uv <= 1'b0;
      sw(6, 4'b0001);
      wr(SC, 32'h0000_0000);
      sup_uv <= 1'b1;
      cyc(6);
      sup_uv <= 1'b0;
      sw(6, 4'b0000);
      rd(CL, 32'h0000_0000);
   endtask
   task automatic s_oc();
      wr(CL, 32'h0000_0001);
      cyc(5);
      short <= 4'b0001;
      cyc(OCC);
      short <= 4'b0000;
      sw(6, 4'b0001);
      short <= 4'b0001;
      sw(OCC + 1, 4'b0001);
      for (int i = 0; i < 20 && sw_on[0] === 1'b1; i++) @(posedge mclk);
      sw(0, 4'b0000);
      short <= 4'b0000;
      rd(CL, 32'h0000_0000);
      cyc(4);
      rd(OCS, 32'h0000_0001);
      wr(OCS, 32'h0000_0001);
      rd(OCS, 32'h0000_0000);
      wr(CL, 32'h0000_0001);
      sw(5, 4'b0001);
   endtask
   task automatic s_ol();
      wr(CL, 32'h0000_0011);
      cyc(5);
      open <= 4'b0010;
      cyc(OLC - 2);
      rd(OLS, 32'h0000_0000);
      cyc(12);
      rd(OLS, 32'h0000_0002);
      sw(0, 4'b0011);
      open <= 4'b0000;
      cyc(OLC + 6);
      rd(OLS, 32'h0000_0002);
      wr(OLS, 32'h0000_0002);
      rd(OLS, 32'h0000_0000);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      cyc(12);
      rst_n <= 1'b1;
      cyc(1);
      s_regs();
      s_sources();
      s_modes();
      s_supply();
      s_oc();
      s_ol();
      conclude();
   end
endmodule
bind hss_top hss_asserts #(.NUM_OUT(NUM_OUT), .OC_CYCLES(OC_CYCLES)) u_chk (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_mode(i_mode), .i_timer(i_timer),
   .i_supply_ov(i_supply_ov), .i_supply_uv(i_supply_uv), .i_oc(i_oc), .i_ol(i_ol),
   .o_switch_on(o_switch_on));
`default_nettype wire
